// ==== design/hss_sequencer.v ====
// duty cycled wake, measure, decide and sleep sequencer
//
// Behaviour
// - first measurement sets output within power-on time
// - latch output, then sleep until next wake
// - output changes only when decision differs
// - first active phase loads calibration memory, 35us
// - then enable current source, settle 5us
// - last phase converts hall sensor, 25us
// - source 80uA on threshold pin during settle and conversion phases
// - threshold current off during sleep
// - read threshold pin each active period
// - setting changed in sleep applies next period
// - release point is operate minus fixed hysteresis
// - omnipolar: either polarity switches alike
// - resistor mode: 1 mT per kohm
// - voltage mode: 0.0125 mT per mV
// - push-pull output driven in both states
// - repeat cycle every 50 ms
// - power-up without field drives output high
`timescale 1ns/100ps
`include "hss_consts.vh"

module hss_sequencer
#(
    parameter [23:0] SAMPLE_PERIOD_CYC = `HSS_SAMPLE_PERIOD_CYC,
    parameter [23:0] OTP_LOAD_CYC = `HSS_OTP_LOAD_CYC,
    parameter [23:0] ISRC_SETTLE_CYC = `HSS_ISRC_SETTLE_CYC,
    parameter [23:0] CONV_CYC = `HSS_CONV_CYC
)
(
    // internal oscillator and power-on reset
    input wire clk,
    input wire resetn,
    // threshold pin reading: mode 1 = resistor (ohms), 0 = voltage (mV)
    input wire threshold_mode_res,
    input wire [15:0] threshold_code,
    // hall conversion result, signed in 1/80 mT units
    input wire [15:0] field_sample,
    // analog control
    output reg otp_load_en,
    output reg isrc_en,
    output reg conv_en,
    // push-pull output: drive enable low in reset, high from first clock after, level from latch
    output reg out_level,
    output reg out_drive_en,
    output reg active
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg mode_s1_reg, mode_s2_reg;
    reg [15:0] code_s1_reg, code_s2_reg;
    reg [15:0] fld_s1_reg, fld_s2_reg;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_s1_reg <= 1'b0;
            mode_s2_reg <= 1'b0;
            code_s1_reg <= 16'h0000;
            code_s2_reg <= 16'h0000;
            fld_s1_reg <= 16'h0000;
            fld_s2_reg <= 16'h0000;
        end
        else
        begin
            mode_s1_reg <= threshold_mode_res;
            mode_s2_reg <= mode_s1_reg;
            code_s1_reg <= threshold_code;
            code_s2_reg <= code_s1_reg;
            fld_s1_reg <= field_sample;
            fld_s2_reg <= fld_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // threshold mapping
    // ------------------------------------------------------------
    wire [31:0] res_units;
    wire [11:0] op_map;

    // ohms * 80 / 1000 gives 1/80 mT units
    assign res_units = ({16'h0000, code_s2_reg} * 32'd`HSS_RES_UNITS_PER_KOHM) / 32'd1000;
    assign op_map = mode_s2_reg ? res_units[11:0]
                                : code_s2_reg[11:0];

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    localparam [1:0] ST_SLEEP = 2'b00;
    localparam [1:0] ST_OTP = 2'b01;
    localparam [1:0] ST_SETTLE = 2'b10;
    localparam [1:0] ST_CONV = 2'b11;

    reg [1:0] state_reg, state_next;
    reg [23:0] phase_cnt_reg, phase_cnt_next;
    reg [23:0] period_cnt_reg;
    reg [11:0] op_reg, op_next;
    reg out_next;
    wire [11:0] rp_now;
    wire dec_out;
    wire wake;

    // period counter runs freely from the oscillator
    assign wake = (period_cnt_reg == SAMPLE_PERIOD_CYC - 24'h000001);
    assign rp_now = (op_reg > `HSS_HYST_UNITS) ? (op_reg - `HSS_HYST_UNITS)
                                               : 12'h000;

    hss_decide u_decide
    (
        .field_sample(fld_s2_reg),
        .operate_point(op_reg),
        .release_point(rp_now),
        .out_now(out_level),
        .out_new(dec_out)
    );

    always @*
    begin
        state_next = state_reg;
        phase_cnt_next = phase_cnt_reg + 24'h000001;
        op_next = op_reg;
        out_next = out_level;
        case (state_reg)
            ST_SLEEP:
            begin
                phase_cnt_next = 24'h000000;
                if (wake)
                    state_next = ST_OTP;
            end
            ST_OTP:
            begin
                if (phase_cnt_reg == OTP_LOAD_CYC - 24'h000001)
                begin
                    state_next = ST_SETTLE;
                    phase_cnt_next = 24'h000000;
                end
            end
            ST_SETTLE:
            begin
                if (phase_cnt_reg == ISRC_SETTLE_CYC - 24'h000001)
                begin
                    state_next = ST_CONV;
                    phase_cnt_next = 24'h000000;
                    op_next = op_map;
                end
            end
            ST_CONV:
            begin
                if (phase_cnt_reg == CONV_CYC - 24'h000001)
                begin
                    state_next = ST_SLEEP;
                    phase_cnt_next = 24'h000000;
                    out_next = dec_out;
                end
            end
            default:
            begin
                state_next = ST_SLEEP;
                phase_cnt_next = 24'h000000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state and counters
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // period counter preset to wake, so the first wake comes on the first clock after reset
            state_reg <= ST_SLEEP;
            phase_cnt_reg <= 24'h000000;
            period_cnt_reg <= SAMPLE_PERIOD_CYC - 24'h000001;
            op_reg <= 12'h000;
        end
        else
        begin
            state_reg <= state_next;
            phase_cnt_reg <= phase_cnt_next;
            period_cnt_reg <= wake ? 24'h000000 : period_cnt_reg + 24'h000001;
            op_reg <= op_next;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_level <= `HSS_OUT_RESET;
            out_drive_en <= 1'b0;
            otp_load_en <= 1'b0;
            isrc_en <= 1'b0;
            conv_en <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            out_level <= out_next;
            out_drive_en <= 1'b1;
            otp_load_en <= (state_next == ST_OTP);
            isrc_en <= (state_next == ST_SETTLE) || (state_next == ST_CONV);
            conv_en <= (state_next == ST_CONV);
            active <= (state_next != ST_SLEEP);
        end
    end

    // codes outside 2..15 mT are mapped without clamping

endmodule // hss_sequencer

// ==== design/hss_consts.vh ====
// timing, scaling and reset constants for the hall switch sequencer
`ifndef HSS_CONSTS_VH
`define HSS_CONSTS_VH

`define HSS_CLK_MHZ 125
`define HSS_OTP_LOAD_US 35
`define HSS_ISRC_SETTLE_US 5
`define HSS_CONV_US 25
`define HSS_SAMPLE_PERIOD_MS 50
`define HSS_OTP_LOAD_CYC (`HSS_OTP_LOAD_US * `HSS_CLK_MHZ)
`define HSS_ISRC_SETTLE_CYC (`HSS_ISRC_SETTLE_US * `HSS_CLK_MHZ)
`define HSS_CONV_CYC (`HSS_CONV_US * `HSS_CLK_MHZ)
`define HSS_SAMPLE_PERIOD_CYC (`HSS_SAMPLE_PERIOD_MS * 1000 * `HSS_CLK_MHZ)
`define HSS_CNT_W 24
// operate point in units of 1/80 mT: 1 mV -> 1 unit (0.0125 mT/mV)
`define HSS_POINT_W 12
// resistance code in ohms -> 1 mT per kohm is 80 units per kohm
`define HSS_RES_UNITS_PER_KOHM 80
`define HSS_HYST_UNITS 12'h050
`define HSS_OUT_RESET 1'b1

`endif

// ==== design/hss_decide.v ====
// omnipolar threshold decision with hysteresis
`timescale 1ns/100ps
`include "hss_consts.vh"

module hss_decide
(
    // field and thresholds
    input wire signed [15:0] field_sample,
    input wire [11:0] operate_point,
    input wire [11:0] release_point,
    // current latched state
    input wire out_now,
    // decided state
    output reg out_new
);

    wire [15:0] mag;

    assign mag = field_sample[15] ? (16'h0000 - field_sample) : field_sample;

    always @*
    begin
        out_new = out_now;
        if (mag >= {4'h0, operate_point})
            out_new = 1'b0;
        else if (mag < {4'h0, release_point})
            out_new = 1'b1;
    end

endmodule // hss_decide

// ==== verif/hss_props.sv ====
// assertion checker for the hall switch sequencer
`timescale 1ns/100ps
module hss_props
#(parameter [23:0] SAMPLE_PERIOD_CYC = 24'h0000C8)
(
    // clock and reset
    input wire clk,
    input wire resetn,
    // device outputs
    input wire otp_load_en,
    input wire isrc_en,
    input wire conv_en,
    input wire out_level,
    input wire out_drive_en,
    input wire active
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
reg [23:0] gap_reg;
reg act_d_reg;
always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
        gap_reg <= 24'h0;
        act_d_reg <= 1'b0;
    end
    else
    begin
        act_d_reg <= active;
        gap_reg <= (active && !act_d_reg) ? 24'h1 : (gap_reg == 24'h0 ? 24'h0 : gap_reg + 24'h1);
    end
sequence settle_s;
    (isrc_en && !conv_en && active)[*4];
endsequence
sequence conv_s;
    (conv_en && isrc_en)[*6];
endsequence
a_otp_len: assert property ($rose(otp_load_en) |-> otp_load_en[*8] ##1 otp_load_en[*2] ##1 !otp_load_en)
    else $error("memory load phase length wrong");
a_settle_len: assert property ($fell(otp_load_en) |-> settle_s ##1 conv_en)
    else $error("settle phase wrong");
a_conv_len: assert property ($rose(conv_en) |-> conv_s ##1 !(conv_en || isrc_en || active))
    else $error("conversion phase wrong");
a_sleep_quiet: assert property (!active |-> !(isrc_en || conv_en || otp_load_en))
    else $error("phase enable high in sleep");
a_out_hold: assert property (!$stable(out_level) |-> $fell(conv_en))
    else $error("output moved outside conversion end");
a_wake_period: assert property ($rose(active) && gap_reg != 24'h0 |-> gap_reg == SAMPLE_PERIOD_CYC)
    else $error("wake period wrong");
a_first_wake: assert property ($rose(resetn) |-> out_level ##1 active && otp_load_en)
    else $error("first wake missing");
a_drive_on: assert property ($past(resetn) |-> out_drive_en)
    else $error("output not driven");
endmodule // hss_props
bind hss_sequencer hss_props #(.SAMPLE_PERIOD_CYC(SAMPLE_PERIOD_CYC)) i_hss_props (.clk(clk),
    .resetn(resetn), .otp_load_en(otp_load_en), .isrc_en(isrc_en), .conv_en(conv_en),
    .out_level(out_level), .out_drive_en(out_drive_en), .active(active));

// ==== verif/hss_thr_src.sv ====
// threshold pin source model
`timescale 1ns/100ps
module hss_thr_src
(
    // device current source
    input wire isrc_en,
    // setting of the source
    input wire [15:0] set_val,
    // pin reading
    output wire [15:0] threshold_code
);
// settles at once when sourced, inverted setting when unsourced
assign threshold_code = isrc_en ? set_val : ~set_val;
endmodule // hss_thr_src

// ==== verif/hss_sequencer_bench.sv ====
// testbench for the hall switch sequencer
`timescale 1ns/100ps
module hss_sequencer_bench;
reg clk = 1'b0;
reg resetn = 1'b0;
reg mode = 1'b1;
reg [15:0] set_val = 16'h0;
reg [15:0] field = 16'h0;
reg prev = 1'b1;
reg rm;
reg e;
wire [15:0] code;
wire otp, isrc, conv, out_level, drv, active;
logic exp_q[$];
integer err_total = 0;
integer num_checks = 0;
integer cyc = 0;
integer i;
always #4 clk = ~clk;
hss_thr_src i_hss_thr_src (.isrc_en(isrc), .set_val(set_val), .threshold_code(code));
hss_sequencer #(.SAMPLE_PERIOD_CYC(24'h0000C8), .OTP_LOAD_CYC(24'h00000A),
    .ISRC_SETTLE_CYC(24'h000004), .CONV_CYC(24'h000006)) i_hss_sequencer (.clk(clk),
    .resetn(resetn), .threshold_mode_res(mode), .threshold_code(code), .field_sample(field),
    .otp_load_en(otp), .isrc_en(isrc), .conv_en(conv), .out_level(out_level),
    .out_drive_en(drv), .active(active));
function automatic logic decide(input logic m, input [15:0] c, input [15:0] f, input logic p);
    reg [31:0] op, a;
    begin
        op = m ? {16'h0, c} * 32'h50 / 32'h3E8 : {20'h0, c[11:0]};
        a = f[15] ? {16'h0, ~f + 16'h1} : {16'h0, f};
        if (a >= op)
            return 1'b0;
        if (op > 32'h50 && a < op - 32'h50)
            return 1'b1;
        return p;
    end
endfunction
task apply(input logic m, input [15:0] c, input [15:0] f);
    begin
        mode <= m;
        set_val <= c;
        field <= f;
        prev = decide(m, c, f, prev);
        exp_q.push_back(prev);
    end
endtask
task one(input logic m, input [15:0] c, input [15:0] f);
    begin
        @(negedge active);
        @(posedge clk);
        apply(m, c, f);
    end
endtask
task give_verdict;
    begin
        if (exp_q.size() != 0)
        begin
            $display("BAD exp_q exp 0 got %0d", exp_q.size());
            err_total = err_total + 1;
        end
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
always @(negedge conv)
begin
    #1;
    if (resetn)
    begin
        if (exp_q.size() == 0)
        begin
            $display("BAD out_level exp none got %b", out_level);
            err_total = err_total + 1;
        end
        else
        begin
            e = exp_q.pop_front();
            num_checks = num_checks + 1;
            if (out_level !== e)
            begin
                $display("BAD out_level exp %b got %b", e, out_level);
                err_total = err_total + 1;
            end
        end
    end
end
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
        err_total = err_total + 1;
        give_verdict;
    end
end
initial
begin
    i = $urandom(74);
    repeat (5) @(posedge clk);
    apply(1'b1, 16'h1388, 16'h01F4);
    resetn <= 1'b1;
    one(1'b1, 16'h1388, 16'hFE70);
    one(1'b1, 16'h1388, 16'h015E);
    one(1'b1, 16'h1388, 16'hFEC1);
    one(1'b0, 16'h0320, 16'h031F);
    one(1'b0, 16'h0320, 16'hFCE0);
    one(1'b0, 16'h00A0, 16'h0064);
    for (i = 0; i < 6; i = i + 1)
    begin
        rm = $urandom % 2;
        one(rm, rm ? 16'(2000 + $urandom % 13001) : 16'(160 + $urandom % 1041),
            16'($urandom % 3201 - 1600));
    end
    @(negedge active);
    #2;
    give_verdict;
end
endmodule // hss_sequencer_bench
